//--- bsme_pkg.sv
package bsme_pkg;

    localparam int PC_W = 16;

    // status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // cycle counts
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_MUL = 3'h2;
    localparam logic [2:0] CYC_JUMP = 3'h2;
    localparam logic [2:0] CYC_CALL = 3'h3;
    localparam logic [2:0] CYC_RET = 3'h4;
    localparam logic [2:0] CYC_TAKEN = 3'h2;
    localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
    localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

    // pc steps
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;

    typedef enum logic [5:0] {
        test_zero_minus_op,
        multiply_unsigned_op,
        multiply_signed_op,
        multiply_signed_unsigned_op,
        fractional_multiply_op,
        fractional_multiply_signed_op,
        fractional_multiply_mixed_op,
        indirect_jump_op,
        indirect_call_op,
        relative_call_op,
        subroutine_return_op,
        interrupt_return_op,
        compare_skip_equal_op,
        compare_op,
        compare_carry_op,
        compare_immediate_op,
        skip_reg_bit_clear_op,
        skip_reg_bit_set_op,
        skip_io_bit_clear_op,
        skip_io_bit_set_op,
        branch_flag_set_op,
        branch_flag_clear_op,
        branch_equal_op,
        branch_not_equal_op,
        branch_carry_set_op,
        branch_carry_clear_op,
        branch_same_higher_op,
        branch_lower_op,
        branch_minus_op,
        branch_plus_op,
        branch_signed_ge_op,
        branch_signed_lt_op,
        branch_half_carry_set_op,
        branch_half_carry_clear_op,
        branch_transfer_set_op,
        branch_transfer_clear_op,
        branch_overflow_set_op,
        branch_overflow_clear_op
    } bsme_op_t;

    typedef struct packed {
        bsme_op_t op;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [2:0] bit_sel;
        logic [PC_W-1:0] offset;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] z_ptr;
        logic [PC_W-1:0] stack_pc;
        logic [7:0] status_register;
        logic next_two_word;
    } bsme_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic pair_we;
        logic [15:0] pair_data;
        logic [7:0] flag_we;
        logic [7:0] flag_val;
        logic pc_we;
        logic [PC_W-1:0] pc_val;
        logic push;
        logic [PC_W-1:0] push_val;
        logic pop;
    } bsme_res_t;

endpackage : bsme_pkg

//--- bsme_multiplier.sv
`timescale 1ns/100ps
module bsme_multiplier
    import bsme_pkg::*;
(
    // operands
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_a_signed,
    input wire logic i_b_signed,
    input wire logic i_frac,
    // product
    output logic [15:0] o_product,
    output logic o_carry,
    output logic o_zero
);
    logic signed [17:0] raw;
    logic signed [8:0] a_ext;
    logic signed [8:0] b_ext;

    always_comb begin
        a_ext = {i_a_signed & i_a[7], i_a};
        b_ext = {i_b_signed & i_b[7], i_b};
        raw = a_ext * b_ext;
        // carry is the product msb before any shift
        o_carry = raw[15];
        o_product = i_frac ? {raw[14:0], 1'b0} : raw[15:0];
        o_zero = (o_product == 16'h0000);
    end
endmodule : bsme_multiplier

//--- bsme_bit_test.sv
`timescale 1ns/100ps
module bsme_bit_test
    import bsme_pkg::*;
(
    // value under test
    input wire logic [7:0] i_value,
    input wire logic [2:0] i_sel,
    input wire logic i_want_set,
    // outcome
    output logic o_hit
);
    always_comb begin
        o_hit = (i_value[i_sel] == i_want_set);
    end
endmodule : bsme_bit_test

//--- bsme_exec.sv
`timescale 1ns/100ps
module bsme_exec
    import bsme_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // request
    input wire logic i_start,
    input wire bsme_req_t i_req,
    // answer
    output bsme_res_t o_res
);

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } bsme_state_t;

    typedef struct packed {
        bsme_state_t state;
        logic [1:0] remaining;
        bsme_res_t pend;
        bsme_res_t out;
    } bsme_regs_t;

    bsme_regs_t state_reg;
    bsme_regs_t state_next;

    // multiplier control
    logic mul_a_signed;
    logic mul_b_signed;
    logic mul_frac;
    logic [15:0] mul_product;
    logic mul_carry;
    logic mul_zero;

    // bit tester control
    logic [7:0] test_value;
    logic [2:0] test_sel;
    logic test_want_set;
    logic test_hit;

    // decoded work for the request
    bsme_res_t work;
    logic [2:0] cycles;

    // subtract flags shared by compare, compare with carry and compare immediate (not the compare skip)
    function automatic logic [7:0] sub_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic cin,
        input logic keep_zero,
        input logic z_old
    );
        logic [7:0] r;
        logic c;
        logic h;
        logic v;
        logic n;
        logic z;
        logic [7:0] f;
        r = a - b - {7'h00, cin};
        c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        n = r[7];
        // carry variant only keeps zero if it was already set
        z = (r == 8'h00) & (~keep_zero | z_old);
        f = 8'h00;
        f[FLAG_C] = c;
        f[FLAG_Z] = z;
        f[FLAG_N] = n;
        f[FLAG_V] = v;
        f[FLAG_S] = n ^ v;
        f[FLAG_H] = h;
        return f;
    endfunction : sub_flags

    function automatic logic [7:0] flag_mask(input logic [2:0] pos);
        logic [7:0] m;
        m = 8'h00;
        m[pos] = 1'b1;
        return m;
    endfunction : flag_mask

    bsme_multiplier u_mult (
        .i_a(i_req.rd_val),
        .i_b(i_req.rr_val),
        .i_a_signed(mul_a_signed),
        .i_b_signed(mul_b_signed),
        .i_frac(mul_frac),
        .o_product(mul_product),
        .o_carry(mul_carry),
        .o_zero(mul_zero)
    );

    bsme_bit_test u_test (
        .i_value(test_value),
        .i_sel(test_sel),
        .i_want_set(test_want_set),
        .o_hit(test_hit)
    );

    // multiplier signedness per variant
    always_comb begin
        mul_a_signed = 1'b0;
        mul_b_signed = 1'b0;
        mul_frac = 1'b0;
        unique case (i_req.op)
            multiply_signed_op: begin
                mul_a_signed = 1'b1;
                mul_b_signed = 1'b1;
            end
            multiply_signed_unsigned_op: begin
                mul_a_signed = 1'b1;
            end
            fractional_multiply_op: begin
                mul_frac = 1'b1;
            end
            fractional_multiply_signed_op: begin
                mul_a_signed = 1'b1;
                mul_b_signed = 1'b1;
                mul_frac = 1'b1;
            end
            fractional_multiply_mixed_op: begin
                mul_a_signed = 1'b1;
                mul_frac = 1'b1;
            end
            default: begin
                mul_a_signed = 1'b0;
            end
        endcase
    end

    // which bit decides a skip or branch, and which level means go
    always_comb begin
        test_value = i_req.status_register;
        test_sel = FLAG_Z;
        test_want_set = 1'b1;
        unique case (i_req.op)
            skip_reg_bit_clear_op, skip_io_bit_clear_op: begin
                // for i/o skips the caller puts the port value in rr_val
                test_value = i_req.rr_val;
                test_sel = i_req.bit_sel;
                test_want_set = 1'b0;
            end
            skip_reg_bit_set_op, skip_io_bit_set_op: begin
                test_value = i_req.rr_val;
                test_sel = i_req.bit_sel;
                test_want_set = 1'b1;
            end
            branch_flag_set_op, branch_flag_clear_op: begin
                test_sel = i_req.bit_sel;
                test_want_set = (i_req.op == branch_flag_set_op);
            end
            branch_equal_op, branch_not_equal_op: begin
                test_sel = FLAG_Z;
                test_want_set = (i_req.op == branch_equal_op);
            end
            branch_carry_set_op, branch_lower_op: begin
                test_sel = FLAG_C;
                test_want_set = 1'b1;
            end
            branch_carry_clear_op, branch_same_higher_op: begin
                test_sel = FLAG_C;
                test_want_set = 1'b0;
            end
            branch_minus_op, branch_plus_op: begin
                test_sel = FLAG_N;
                test_want_set = (i_req.op == branch_minus_op);
            end
            branch_signed_ge_op, branch_signed_lt_op: begin
                // signed order uses n xor v, not the stored s bit
                test_value = {7'h00, i_req.status_register[FLAG_N] ^
                    i_req.status_register[FLAG_V]};
                test_sel = 3'h0;
                test_want_set = (i_req.op == branch_signed_lt_op);
            end
            branch_half_carry_set_op, branch_half_carry_clear_op: begin
                test_sel = FLAG_H;
                test_want_set = (i_req.op == branch_half_carry_set_op);
            end
            branch_transfer_set_op, branch_transfer_clear_op: begin
                test_sel = FLAG_T;
                test_want_set = (i_req.op == branch_transfer_set_op);
            end
            branch_overflow_set_op, branch_overflow_clear_op: begin
                test_sel = FLAG_V;
                test_want_set = (i_req.op == branch_overflow_set_op);
            end
            default: begin
                test_sel = FLAG_Z;
            end
        endcase
    end

    // effect and length of the request
    always_comb begin
        logic [7:0] and_val;
        logic [7:0] test_flags;
        logic skip;
        and_val = i_req.rd_val & i_req.rd_val;
        test_flags = 8'h00;
        skip = 1'b0;
        work = '0;
        work.done = 1'b1;
        work.pc_we = 1'b1;
        work.pc_val = i_req.pc + PC_STEP;
        cycles = CYC_ONE;
        unique case (i_req.op)
            test_zero_minus_op: begin
                // register is left as is, so no write back
                test_flags[FLAG_Z] = (and_val == 8'h00);
                test_flags[FLAG_N] = and_val[7];
                test_flags[FLAG_V] = 1'b0;
                work.flag_val = test_flags;
                work.flag_we = flag_mask(FLAG_Z) | flag_mask(FLAG_N) | flag_mask(FLAG_V);
                cycles = CYC_ONE;
            end
            multiply_unsigned_op, multiply_signed_op, multiply_signed_unsigned_op,
            fractional_multiply_op, fractional_multiply_signed_op,
            fractional_multiply_mixed_op: begin
                work.pair_we = 1'b1;
                work.pair_data = mul_product;
                work.flag_we = flag_mask(FLAG_Z) | flag_mask(FLAG_C);
                work.flag_val[FLAG_Z] = mul_zero;
                work.flag_val[FLAG_C] = mul_carry;
                cycles = CYC_MUL;
            end
            indirect_jump_op: begin
                work.pc_val = i_req.z_ptr;
                cycles = CYC_JUMP;
            end
            indirect_call_op: begin
                work.push = 1'b1;
                work.push_val = i_req.pc + PC_STEP;
                work.pc_val = i_req.z_ptr;
                cycles = CYC_CALL;
            end
            relative_call_op: begin
                work.push = 1'b1;
                work.push_val = i_req.pc + PC_STEP;
                work.pc_val = i_req.pc + i_req.offset + PC_STEP;
                cycles = CYC_CALL;
            end
            subroutine_return_op: begin
                work.pop = 1'b1;
                work.pc_val = i_req.stack_pc;
                cycles = CYC_RET;
            end
            interrupt_return_op: begin
                work.pop = 1'b1;
                work.pc_val = i_req.stack_pc;
                work.flag_we = flag_mask(FLAG_I);
                work.flag_val[FLAG_I] = 1'b1;
                cycles = CYC_RET;
            end
            compare_op, compare_immediate_op: begin
                // immediate arrives in rr_val; nothing is written back
                work.flag_val = sub_flags(i_req.rd_val, i_req.rr_val, 1'b0, 1'b0,
                    1'b0);
                work.flag_we = 8'h3F;
                cycles = CYC_ONE;
            end
            compare_carry_op: begin
                work.flag_val = sub_flags(i_req.rd_val, i_req.rr_val,
                    i_req.status_register[FLAG_C], 1'b1,
                    i_req.status_register[FLAG_Z]);
                work.flag_we = 8'h3F;
                cycles = CYC_ONE;
            end
            compare_skip_equal_op: begin
                skip = (i_req.rd_val == i_req.rr_val);
            end
            skip_reg_bit_clear_op, skip_reg_bit_set_op,
            skip_io_bit_clear_op, skip_io_bit_set_op: begin
                skip = test_hit;
            end
            default: begin
                // every remaining op is a conditional branch
                if (test_hit) begin
                    work.pc_val = i_req.pc + i_req.offset + PC_STEP;
                    cycles = CYC_TAKEN;
                end else begin
                    cycles = CYC_ONE;
                end
            end
        endcase
        if (skip) begin
            // skip length follows the size of the skipped instruction
            if (i_req.next_two_word) begin
                work.pc_val = i_req.pc + PC_SKIP_TWO;
                cycles = CYC_SKIP_TWO;
            end else begin
                work.pc_val = i_req.pc + PC_SKIP_ONE;
                cycles = CYC_SKIP_ONE;
            end
        end
    end

    // sequencer: results are held back until the last cycle
    always_comb begin
        state_next = state_reg;
        state_next.out = '0;
        unique case (state_reg.state)
            ST_IDLE: begin
                if (i_start) begin
                    if (cycles == CYC_ONE) begin
                        state_next.out = work;
                    end else begin
                        state_next.state = ST_RUN;
                        state_next.pend = work;
                        state_next.remaining = 2'(cycles - CYC_MUL);
                        state_next.out.busy = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (state_reg.remaining == 2'h0) begin
                    state_next.out = state_reg.pend;
                    state_next.state = ST_IDLE;
                end else begin
                    state_next.remaining = state_reg.remaining - 2'h1;
                    state_next.out.busy = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '{state: ST_IDLE, remaining: 2'h0, pend: '0, out: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_res = state_reg.out;

endmodule : bsme_exec

//--- bsme_exec_monitor.sv
`timescale 1ns/100ps
module bsme_exec_monitor
    import bsme_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // watched ports
    input wire logic i_start,
    input wire bsme_req_t i_req,
    input wire bsme_res_t o_res
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    logic take;
    logic [2:0] cnt_reg;
    bsme_req_t cap_reg;
    logic [15:0] uprod;

    assign take = i_start && !o_res.busy;
    assign uprod = {8'h00, cap_reg.rd_val} * {8'h00, cap_reg.rr_val};

    // cycles since take, equals the instruction length at done
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_reg <= 3'h0;
            cap_reg <= '0;
        end else if (take) begin
            cnt_reg <= 3'h1;
            cap_reg <= i_req;
        end else if (o_res.busy) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    AST_TEST_ONE: assert property (take && i_req.op == test_zero_minus_op |=>
        o_res.done && o_res.flag_we == 8'h0E && !o_res.pair_we
        && o_res.flag_val[FLAG_Z] == (cap_reg.rd_val == 8'h00)
        && o_res.flag_val[FLAG_N] == cap_reg.rd_val[7]) else $error("test op wrong");
    AST_MUL_TWO: assert property (take && i_req.op inside {multiply_unsigned_op,
        multiply_signed_op, multiply_signed_unsigned_op} |=> o_res.busy && !o_res.done
        ##1 o_res.done && o_res.pair_we && o_res.flag_we == 8'h03) else $error("mul timing");
    AST_MUL_VALUE: assert property (take && i_req.op == multiply_unsigned_op |-> ##2
        o_res.pair_data == uprod && o_res.flag_val[FLAG_C] == uprod[15]
        && o_res.flag_val[FLAG_Z] == (uprod == 16'h0000)) else $error("mul value");
    AST_FRAC_VALUE: assert property (take && i_req.op == fractional_multiply_op |->
        ##2 o_res.done && o_res.pair_data == {uprod[14:0], 1'b0}
        && o_res.flag_val[FLAG_C] == uprod[15] && o_res.flag_we == 8'h03)
        else $error("fractional value");
    AST_IND_JUMP: assert property (take && i_req.op == indirect_jump_op |=> o_res.busy
        ##1 o_res.done && o_res.pc_we && o_res.pc_val == cap_reg.z_ptr
        && o_res.flag_we == 8'h00) else $error("indirect jump");
    AST_CALL: assert property (take && i_req.op inside {indirect_call_op,
        relative_call_op} |=> o_res.busy [*2] ##1 o_res.done && o_res.push
        && o_res.push_val == cap_reg.pc + PC_STEP) else $error("call");
    AST_RETURN: assert property (take && i_req.op inside {subroutine_return_op,
        interrupt_return_op} |=> o_res.busy [*3] ##1 o_res.done && o_res.pop
        && o_res.pc_val == cap_reg.stack_pc
        && o_res.flag_we[FLAG_I] == (cap_reg.op == interrupt_return_op)) else $error("return");
    AST_CMP: assert property (take && i_req.op inside {compare_op, compare_carry_op,
        compare_immediate_op} |=> o_res.done && o_res.flag_we == 8'h3F && !o_res.pair_we)
        else $error("compare");
    AST_SKIP: assert property (o_res.done && cap_reg.op inside {compare_skip_equal_op,
        skip_reg_bit_clear_op, skip_reg_bit_set_op, skip_io_bit_clear_op,
        skip_io_bit_set_op} |-> o_res.pc_val == cap_reg.pc + 16'(cnt_reg)
        && (cnt_reg != 3'h3 || cap_reg.next_two_word) && (cnt_reg != 3'h2
        || !cap_reg.next_two_word) && o_res.flag_we == 8'h00) else $error("skip");
    AST_BRANCH: assert property (o_res.done
        && cap_reg.op inside {[branch_flag_set_op:branch_overflow_clear_op]}
        |-> cnt_reg inside {3'h1, 3'h2} && o_res.flag_we == 8'h00 && o_res.pc_val
        == cap_reg.pc + ((cnt_reg == 3'h2) ? cap_reg.offset + PC_STEP : PC_STEP))
        else $error("branch target");
    AST_BR_GE: assert property (o_res.done && cap_reg.op == branch_signed_ge_op |->
        (cnt_reg == 3'h2) == !(cap_reg.status_register[FLAG_N]
        ^ cap_reg.status_register[FLAG_V])) else $error("signed ge");

    COV_MUL: cover property (o_res.done && o_res.pair_we);
    COV_BR_TAKEN: cover property (o_res.done && cnt_reg == 3'h2 && cap_reg.op == branch_equal_op);
    COV_SKIP_TWO: cover property (o_res.done && cnt_reg == 3'h3 && !o_res.push);
endmodule : bsme_exec_monitor

//--- bsme_exec_test.sv
`timescale 1ns/100ps
module bsme_exec_test;
    import bsme_pkg::*;
    logic i_clk;
    logic i_reset;
    logic i_start;
    bsme_req_t i_req;
    bsme_res_t o_res;
    bsme_res_t got;
    int err_total;
    int checks_done;
    int n_seen;
    // leaves start up so the next request lands in the done cycle
    bit keep_start;

    bsme_exec dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_req(i_req),
        .o_res(o_res));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask : check

    function automatic bsme_req_t mk(input bsme_op_t op, input logic [7:0] a,
        input logic [7:0] b);
        mk = '0;
        mk.op = op;
        mk.rd_val = a;
        mk.rr_val = b;
        mk.bit_sel = FLAG_H;
        mk.pc = 16'h0100;
        mk.offset = 16'hFFF0;
        mk.z_ptr = 16'h2345;
        mk.stack_pc = 16'h0ABC;
    endfunction : mk

    // now=1 raises start inside a done cycle, the back-to-back case
    task automatic issue(input bsme_req_t r, input bit now);
        if (!now) begin
            @(posedge i_clk);
            #1;
        end
        i_req = r;
        i_start = 1'b1;
        @(posedge i_clk);
        #1;
        if (!keep_start) begin
            i_start = 1'b0;
        end
        n_seen = 1;
        while (o_res.done !== 1'b1) begin
            if (n_seen > 6) begin
                err_total++;
                complete_run();
            end
            @(posedge i_clk);
            #1;
            n_seen++;
        end
        got = o_res;
    endtask : issue

    task automatic t_test();
        keep_start = 1'b1;
        issue(mk(test_zero_minus_op, 8'h80, 8'h00), 1'b0);
        keep_start = 1'b0;
        check(32'(n_seen), 32'h1);
        check(32'({got.flag_we, got.flag_val, 7'h00, got.pair_we}), 32'h000E_0400);
        issue(mk(test_zero_minus_op, 8'h00, 8'h00), 1'b1);
        check(32'({got.flag_we, got.flag_val, 7'h00, got.pair_we}), 32'h000E_0200);
    endtask : t_test

    task automatic t_mul();
        bsme_op_t ops [6] = '{multiply_unsigned_op, multiply_signed_op,
            multiply_signed_unsigned_op, fractional_multiply_op,
            fractional_multiply_signed_op, fractional_multiply_mixed_op};
        logic [15:0] prod [6] = '{16'h02FA, 16'hFFFA, 16'hFFFA, 16'h05F4, 16'hFFF4, 16'hFFF4};
        logic [1:0] zc [6] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1};
        for (int k = 0; k < 6; k++) begin
            issue(mk(ops[k], 8'hFE, 8'h03), 1'b0);
            check(32'(n_seen), 32'h2);
            check(32'({got.pair_we, got.pair_data}), 32'({1'b1, prod[k]}));
            check(32'({got.flag_we, got.flag_val}), 32'({8'h03, 6'h00, zc[k]}));
        end
        issue(mk(fractional_multiply_op, 8'h80, 8'h80), 1'b0);
        check({got.pair_data, got.flag_val, got.flag_we}, 32'h8000_0003);
        issue(mk(multiply_signed_op, 8'h00, 8'h7F), 1'b0);
        check({got.pair_data, got.flag_val, got.flag_we}, 32'h0000_0203);
    endtask : t_mul

    task automatic t_flow();
        issue(mk(indirect_jump_op, 8'h00, 8'h00), 1'b0);
        check(32'(n_seen), 32'h2);
        check(32'({got.pc_we, got.pc_val, got.flag_we}), 32'h0123_4500);
        issue(mk(indirect_call_op, 8'h00, 8'h00), 1'b0);
        check(32'(n_seen), 32'h3);
        check({got.push_val, got.pc_val}, 32'h0101_2345);
        issue(mk(relative_call_op, 8'h00, 8'h00), 1'b0);
        check({got.push_val, got.pc_val}, 32'h0101_00F1);
        issue(mk(subroutine_return_op, 8'h00, 8'h00), 1'b0);
        check(32'(n_seen), 32'h4);
        check(32'({got.pop, got.push, got.pc_val, got.flag_we}), 32'h020A_BC00);
        issue(mk(interrupt_return_op, 8'h00, 8'h00), 1'b0);
        check(32'(n_seen), 32'h4);
        check({got.pc_val, got.flag_we, got.flag_val}, 32'h0ABC_8080);
        check(32'(got.pop), 32'h1);
    endtask : t_flow

    task automatic cmp1(input bsme_op_t op, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] sr, input logic [7:0] want);
        bsme_req_t r;
        r = mk(op, a, b);
        r.status_register = sr;
        issue(r, 1'b0);
        check(32'(n_seen), 32'h1);
        check({got.flag_we, got.flag_val, got.pc_val}, {8'h3F, want, 16'h0101});
    endtask : cmp1

    task automatic t_skip();
        bsme_op_t ops [8] = '{compare_skip_equal_op, compare_skip_equal_op,
            compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
            skip_reg_bit_set_op, skip_io_bit_clear_op, skip_io_bit_set_op};
        logic [7:0] b [8] = '{8'h5A, 8'h5B, 8'h5A, 8'hFB, 8'h04, 8'hFB, 8'h80, 8'h80};
        logic [2:0] sel [8] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2, 3'h7, 3'h7};
        logic two [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        logic [1:0] n [8] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h2, 2'h1, 2'h1, 2'h3};
        bsme_req_t r;
        for (int k = 0; k < 8; k++) begin
            r = mk(ops[k], 8'h5A, b[k]);
            r.bit_sel = sel[k];
            r.next_two_word = two[k];
            issue(r, 1'b0);
            check(32'(n_seen), 32'(n[k]));
            check({got.pc_val, got.flag_we}, {16'h0100 + 16'(n[k]), 8'h00});
        end
    endtask : t_skip

    function automatic logic br_taken(input bsme_op_t op, input logic [7:0] s);
        case (op)
            branch_flag_set_op: br_taken = s[FLAG_H];
            branch_flag_clear_op: br_taken = !s[FLAG_H];
            branch_equal_op: br_taken = s[FLAG_Z];
            branch_not_equal_op: br_taken = !s[FLAG_Z];
            branch_carry_set_op, branch_lower_op: br_taken = s[FLAG_C];
            branch_carry_clear_op, branch_same_higher_op: br_taken = !s[FLAG_C];
            branch_minus_op: br_taken = s[FLAG_N];
            branch_plus_op: br_taken = !s[FLAG_N];
            branch_signed_ge_op: br_taken = !(s[FLAG_N] ^ s[FLAG_V]);
            branch_signed_lt_op: br_taken = s[FLAG_N] ^ s[FLAG_V];
            branch_half_carry_set_op: br_taken = s[FLAG_H];
            branch_half_carry_clear_op: br_taken = !s[FLAG_H];
            branch_transfer_set_op: br_taken = s[FLAG_T];
            branch_transfer_clear_op: br_taken = !s[FLAG_T];
            branch_overflow_set_op: br_taken = s[FLAG_V];
            default: br_taken = !s[FLAG_V];
        endcase
    endfunction : br_taken

    task automatic t_branch();
        logic [7:0] srs [4] = '{8'h00, 8'hFF, 8'h04, 8'h69};
        bsme_req_t r;
        logic t;
        for (int o = int'(branch_flag_set_op); o <= int'(branch_overflow_clear_op); o++) begin
            for (int k = 0; k < 4; k++) begin
                r = mk(bsme_op_t'(o), 8'h00, 8'h00);
                r.status_register = srs[k];
                t = br_taken(r.op, srs[k]);
                issue(r, 1'b0);
                check(32'(n_seen), t ? 32'h2 : 32'h1);
                check({got.pc_val, got.flag_we}, {t ? 16'h00F1 : 16'h0101, 8'h00});
            end
        end
    endtask : t_branch

    // start held through busy: refused there, taken in the done cycle
    task automatic t_overlap();
        @(posedge i_clk);
        #1;
        i_req = mk(multiply_unsigned_op, 8'h02, 8'h03);
        i_start = 1'b1;
        @(posedge i_clk);
        #1;
        i_req = mk(compare_op, 8'h01, 8'h01);
        @(posedge i_clk);
        #1;
        check(32'({o_res.done, o_res.pair_data}), 32'h1_0006);
        @(posedge i_clk);
        #1;
        i_start = 1'b0;
        check(32'({o_res.done, o_res.flag_we, o_res.flag_val}), 32'h1_3F02);
        @(posedge i_clk);
        #1;
        check(32'(o_res.done), 32'h0);
    endtask : t_overlap

    initial begin
        err_total = 0;
        checks_done = 0;
        i_reset = 1'b1;
        i_start = 1'b0;
        i_req = '0;
        repeat (20) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        t_test();
        t_mul();
        t_flow();
        cmp1(compare_op, 8'h10, 8'h20, 8'h00, 8'h15);
        cmp1(compare_carry_op, 8'h20, 8'h1F, 8'h01, 8'h20);
        cmp1(compare_carry_op, 8'h20, 8'h1F, 8'h03, 8'h22);
        cmp1(compare_immediate_op, 8'h80, 8'h01, 8'h00, 8'h38);
        t_skip();
        t_branch();
        t_overlap();
        complete_run();
    end
endmodule : bsme_exec_test

bind bsme_exec bsme_exec_monitor mon_u (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start),
    .i_req(i_req), .o_res(o_res));
